/* verilog/dma_ctrl_stat.sv */
`timescale 1ns/1ps
module dma_ctrl_stat
  import dma_ctrl_pkg::*;
#(
  parameter logic [BOFF_W-1:0] BACKOFF_BASE_CYC_P = BOFF_BASE_CYC
) (
  input  logic              mclk_in,
  input  logic              sys_rst_in,
  input  logic              ce_in,
  input  logic              reg_wr_in,
  input  logic              reg_rd_in,
  input  logic [11:0]       reg_addr_in,
  input  logic [31:0]       reg_wdata_in,
  output logic [31:0]       reg_rdata_out,
  input  logic              pci_master_en_in,
  input  logic [2:0]        pci_addr_lo_in,
  input  logic [2:0]        vme_addr_lo_in,
  input  logic              pci_err_in,
  input  logic              vme_err_in,
  input  logic              packet_done_in,
  input  logic              xfer_done_in,
  input  logic              pci_dma_irq_en_in,
  input  logic              src_valid_in,
  input  logic [DATA_W-1:0] src_data_in,
  output logic              src_ready_out,
  output logic              sink_valid_out,
  output logic [DATA_W-1:0] sink_data_out,
  input  logic              sink_ready_in,
  input  logic              vme_gnt_in,
  output logic              vme_req_out,
  output logic              start_out,
  output logic              chain_mode_out,
  output logic              running_out,
  output logic              irq_out
);
  eng_state_t         state_q;
  eng_state_t         state_d;
  logic               run_q;
  logic               run_d;
  logic               cease_why_q;
  logic               cease_why_d;
  logic               pause_pend_q;
  logic               chain_q;
  logic [2:0]         ten_code_q;
  logic [3:0]         boff_code_q;
  logic [5:0]         ien_q;
  logic [5:0]         ien_d;
  logic [5:0]         flags_q;
  logic [5:0]         flags_d;
  logic [5:0]         flag_set;
  logic [5:0]         flag_w1c;
  logic [TEN_W-1:0]   ten_cnt_q;
  logic [TEN_W-1:0]   ten_limit;
  logic [BOFF_W-1:0]  boff_q;
  logic [BOFF_W-1:0]  boff_d;
  logic               vme_req_q;
  logic               start_q;
  logic               irq_q;
  logic [31:0]        rdata_q;
  logic [31:0]        stat_word;
  logic               fifo_empty;
  wire                wr_hit;
  wire                rd_hit;
  wire                launch_wr;
  wire                cease_wr;
  wire                pause_wr;
  wire                idle;
  wire                launch_ok;
  wire                launch_bad;
  wire                err_end;
  wire                pause_end;
  wire                drain_end;
  wire                beat;
  wire                tenure_end;

  default clocking @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);

  // register port decode, unmapped addresses are ignored
  assign wr_hit    = reg_wr_in && (reg_addr_in == CTRL_STAT_OFS);
  assign rd_hit    = reg_rd_in && (reg_addr_in == CTRL_STAT_OFS);
  assign launch_wr = wr_hit && reg_wdata_in[B_LAUNCH];
  assign cease_wr  = wr_hit && reg_wdata_in[B_CEASE];
  assign pause_wr  = wr_hit && reg_wdata_in[B_PAUSE];
  assign idle      = (state_q == ST_IDLE);

  // [RL12] launch legality check
  assign launch_bad = launch_wr && idle &&
                      !(pci_master_en_in && (pci_addr_lo_in == vme_addr_lo_in));
  // [RL19] launch only from idle
  assign launch_ok  = launch_wr && idle && !launch_bad;

  // end conditions; errors outrank every other reason
  assign err_end   = !idle && (pci_err_in || vme_err_in);
  // [RL2] pause at packet boundary
  assign pause_end = (state_q == ST_RUN) && chain_q && (pause_pend_q || pause_wr) &&
                     packet_done_in && !err_end;
  // [RL1] end after buffer empties
  assign drain_end = (state_q == ST_DRAIN) && fifo_empty && !err_end;

  // [RL7] sticky ended-early flag
  assign flag_set[F_STOP] = drain_end && cease_why_q;
  // [RL8] sticky paused flag
  assign flag_set[F_HALT] = pause_end;
  // [RL9] sticky complete flag
  assign flag_set[F_DONE] = drain_end && !cease_why_q;
  // [RL10] pci error capture
  assign flag_set[F_PCI]  = !idle && pci_err_in;
  // [RL11] vme error capture
  assign flag_set[F_VME]  = !idle && vme_err_in;
  assign flag_set[F_PROG] = launch_bad;

  // write one clears, a same-cycle set wins over the clear
  assign flag_w1c = wr_hit ? unpack_six(reg_wdata_in[B_FLAG_LO +: FLD_W]) : '0;
  assign flags_d  = (flags_q & ~flag_w1c) | flag_set;
  // [RL13] [RL14] per-source interrupt enables
  assign ien_d    = wr_hit ? unpack_six(reg_wdata_in[B_IEN_LO +: FLD_W]) : ien_q;

  // engine sequencing
  always_comb begin
    state_d     = state_q;
    cease_why_d = cease_why_q;
    unique case (state_q)
      ST_IDLE: begin
        if (launch_ok) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (err_end || pause_end) begin
          state_d = ST_IDLE;
        end else if (cease_wr || xfer_done_in) begin
          state_d     = ST_DRAIN;
          cease_why_d = cease_wr;
        end
      end
      ST_DRAIN: begin
        if (err_end || drain_end) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // [RL20] running drops with flag set
  assign run_d = (state_d != ST_IDLE);

  // vme tenure: count beats while we hold the bus
  assign beat       = sink_valid_out && sink_ready_in && vme_gnt_in && vme_req_q;
  assign ten_limit  = tenure_beats(ten_code_q);
  // [RL4] tenure byte cap
  assign tenure_end = beat && (ten_code_q != 3'h0) && (ten_cnt_q == ten_limit - TEN_W'(1));
  // [RL5] backoff before re-request
  assign boff_d     = tenure_end ? backoff_cycles(boff_code_q, BACKOFF_BASE_CYC_P) :
                      (boff_q != '0) ? boff_q - BOFF_W'(1) : '0;

  // read image; write-only request bits always return zero
  assign stat_word = (32'(chain_q) << B_CHAIN) |
                     (32'(ten_code_q) << B_TEN_LO) |
                     (32'(boff_code_q) << B_BOFF_LO) |
                     (32'(run_q) << B_RUN) |
                     (32'(pack_six(flags_q)) << B_FLAG_LO) |
                     (32'(pack_six(ien_q)) << B_IEN_LO);

  // engine state and status
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      state_q      <= ST_IDLE;
      run_q        <= 1'b0;
      cease_why_q  <= 1'b0;
      pause_pend_q <= 1'b0;
      flags_q      <= unpack_six(CTRL_STAT_RST[B_FLAG_LO +: FLD_W]);
      start_q      <= 1'b0;
    end else if (ce_in) begin
      state_q      <= state_d;
      // [RL6] running status flop
      run_q        <= run_d;
      cease_why_q  <= cease_why_d;
      pause_pend_q <= (state_d == ST_RUN) && (pause_pend_q || (pause_wr && !idle));
      flags_q      <= flags_d;
      start_q      <= launch_ok;
    end
  end

  // software configuration
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      chain_q     <= CTRL_STAT_RST[B_CHAIN];
      ten_code_q  <= CTRL_STAT_RST[B_TEN_LO +: 3];
      boff_code_q <= CTRL_STAT_RST[B_BOFF_LO +: 4];
      ien_q       <= unpack_six(CTRL_STAT_RST[B_IEN_LO +: FLD_W]);
    end else if (ce_in) begin
      if (wr_hit) begin
        // [RL3] mode select bit
        chain_q     <= reg_wdata_in[B_CHAIN];
        ten_code_q  <= reg_wdata_in[B_TEN_LO +: 3];
        boff_code_q <= reg_wdata_in[B_BOFF_LO +: 4];
      end
      ien_q <= ien_d;
    end
  end

  // bus ownership, interrupt and read data
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      ten_cnt_q <= '0;
      boff_q    <= '0;
      vme_req_q <= 1'b0;
      irq_q     <= 1'b0;
      rdata_q   <= '0;
    end else if (ce_in) begin
      ten_cnt_q <= (!run_d || tenure_end) ? '0 : ten_cnt_q + TEN_W'(beat);
      boff_q    <= boff_d;
      vme_req_q <= run_d && (boff_d == '0) && !tenure_end;
      // [RL18] top-level dma enable gate
      irq_q     <= pci_dma_irq_en_in && |(flags_d & ien_d);
      rdata_q   <= rd_hit ? stat_word : '0;
    end
  end

  assign reg_rdata_out  = rdata_q;
  assign vme_req_out    = vme_req_q;
  assign start_out      = start_q;
  assign chain_mode_out = chain_q;
  assign running_out    = run_q;
  assign irq_out        = irq_q;

  // data buffer; an error end or a new launch throws away stale words
  dma_stream_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_in        (mclk_in),
    .rst_in        (sys_rst_in),
    .ce_in         (ce_in),
    .flush_in      (err_end || launch_ok),
    .in_en_in      (state_d == ST_RUN),
    .in_valid_in   (src_valid_in),
    .in_data_in    (src_data_in),
    .in_ready_out  (src_ready_out),
    .out_valid_out (sink_valid_out),
    .out_data_out  (sink_data_out),
    .out_ready_in  (sink_ready_in && vme_gnt_in && vme_req_q),
    .empty_out     (fifo_empty)
  );

  sequence s_launch_good;
    ce_in && launch_ok;
  endsequence

  sequence s_running;
    run_q && (state_q == ST_RUN);
  endsequence

  launch_starts_a: assert property (s_launch_good |=> s_running ##0 start_out) // [RL19]
    else $error("launch did not start engine");

  bad_launch_a: assert property (ce_in && launch_bad |=> flags_q[F_PROG] && !run_q) // [RL12]
    else $error("bad launch not faulted");

  cease_drain_a: assert property (ce_in && state_q == ST_DRAIN && !fifo_empty && !err_end // [RL1]
    |=> state_q == ST_DRAIN)
    else $error("cease ended before buffer empty");

  pause_end_a: assert property (ce_in && pause_end |=> flags_q[F_HALT] && !run_q) // [RL8]
    else $error("pause did not set paused flag");

  direct_no_pause_a: assert property (ce_in && !chain_q && !flags_q[F_HALT] // [RL3]
    |=> !flags_q[F_HALT])
    else $error("pause taken in direct mode");

  done_flag_a: assert property (ce_in && drain_end && !cease_why_q // [RL9]
    |=> flags_q[F_DONE] && state_q == ST_IDLE)
    else $error("complete flag missing");

  stop_sticky_a: assert property (ce_in && flags_q[F_STOP] && !flag_w1c[F_STOP] // [RL7]
    |=> flags_q[F_STOP])
    else $error("ended early flag lost");

  pci_err_a: assert property (ce_in && !idle && pci_err_in |=> flags_q[F_PCI] && !run_q) // [RL10]
    else $error("pci error not captured");

  vme_err_a: assert property (ce_in && !idle && vme_err_in |=> flags_q[F_VME] && !run_q) // [RL11]
    else $error("vme error not captured");

  run_clear_a: assert property (ce_in && |flag_set[F_STOP:F_VME] |=> !run_q) // [RL20]
    else $error("running held after end");

  run_read_a: assert property (ce_in && rd_hit |=> reg_rdata_out[B_RUN] == $past(run_q)) // [RL6]
    else $error("running readback wrong");

  req_zero_a: assert property (reg_rdata_out[B_LAUNCH:B_PAUSE] == 3'h0) // [RL19]
    else $error("request bits read nonzero");

  irq_gate_a: assert property (ce_in |=> irq_out == // [RL13]
    ($past(pci_dma_irq_en_in) && |(flags_q & ien_q)))
    else $error("interrupt not gated by enables");

  irq_off_a: assert property (ce_in && !pci_dma_irq_en_in |=> !irq_out) // [RL18]
    else $error("interrupt passed while disabled");

  tenure_drop_a: assert property (ce_in && tenure_end |=> !vme_req_out) // [RL4]
    else $error("bus kept past tenure cap");

  backoff_wait_a: assert property (boff_q != '0 |-> !vme_req_out) // [RL5]
    else $error("bus requested during backoff");

  err_mask_a: assert property (ce_in && ien_q[F_PROG] == 1'b0 && flags_q == 6'h01 // [RL14]
    && !wr_hit && idle && !launch_wr |=> !irq_out)
    else $error("masked fault raised interrupt");
endmodule

/* verilog/dma_ctrl_pkg.sv */
// Behaviour
// [RL1] cease request ends after buffered data drains
// [RL2] pause request stops at packet end
// [RL3] chain bit selects direct or linked mode
// [RL4] tenure code caps bytes per bus hold
// [RL5] backoff code delays next bus request
// [RL6] running bit shows transfer in progress
// [RL7] ended-early flag sticky, write one clears
// [RL8] paused flag sticky, write one clears
// [RL9] complete flag sticky, write one clears
// [RL10] pci error flag sticky, write one clears
// [RL11] vme error flag sticky, write one clears
// [RL12] bad launch sets fault, moves nothing
// [RL13] enables gate end-early, pause, complete interrupts
// [RL14] enables gate error and fault interrupts
// [RL15] software clears flags before launching
// [RL16] linked mode needs zero byte count
// [RL17] command packets are 32-byte aligned
// [RL18] pci dma enable gates interrupt output
// [RL19] launch starts transfer, reads as zero
// [RL20] running clears with the ending flag
package dma_ctrl_pkg;
  // register map
  localparam logic [11:0] CTRL_STAT_OFS = 12'h220;
  localparam logic [31:0] CTRL_STAT_RST = 32'h0000_0000;
  localparam int B_LAUNCH  = 31;
  localparam int B_CEASE   = 30;
  localparam int B_PAUSE   = 29;
  localparam int B_CHAIN   = 27;
  localparam int B_TEN_LO  = 20;
  localparam int B_BOFF_LO = 16;
  localparam int B_RUN     = 15;
  localparam int B_FLAG_LO = 8;
  localparam int B_IEN_LO  = 0;
  localparam int FLD_W     = 7;
  // six-entry flag order: ended early, paused, complete, pci, vme, fault
  localparam int F_STOP = 5;
  localparam int F_HALT = 4;
  localparam int F_DONE = 3;
  localparam int F_PCI  = 2;
  localparam int F_VME  = 1;
  localparam int F_PROG = 0;
  // timing and sizes
  localparam int CLK_PERIOD_NS    = 4;
  localparam int BOFF_BASE_NS     = 2000;
  localparam int BOFF_W           = 20;
  localparam logic [BOFF_W-1:0] BOFF_BASE_CYC =
    BOFF_W'((BOFF_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] BOFF_LONG_MAX  = 4'h7;
  localparam logic [3:0] BOFF_SHORT_MIN = 4'h8;
  localparam logic [3:0] BOFF_SHORT_MAX = 4'hA;
  localparam logic [3:0] BOFF_LONG_ADJ  = 4'h2;
  localparam int TEN_BASE_BYTES = 256;
  localparam int BYTES_PER_BEAT = 4;
  localparam int TEN_W          = 13;
  localparam logic [TEN_W-1:0] TEN_BASE_BEATS = TEN_W'(TEN_BASE_BYTES / BYTES_PER_BEAT);
  localparam int DATA_W     = 32;
  localparam int FIFO_DEPTH = 32;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_RUN   = 2'b01,
    ST_DRAIN = 2'b10
  } eng_state_t;

  // register field (bit 4 is a hole) to six-entry vector
  function automatic logic [5:0] unpack_six(input logic [FLD_W-1:0] f);
    return {f[6], f[5], f[3], f[2], f[1], f[0]};
  endfunction

  function automatic logic [FLD_W-1:0] pack_six(input logic [5:0] v);
    return {v[5], v[4], 1'b0, v[3], v[2], v[1], v[0]};
  endfunction

  // beats per tenure, code 0 means no cap
  function automatic logic [TEN_W-1:0] tenure_beats(input logic [2:0] code);
    return TEN_BASE_BEATS << (code - 3'h1);
  endfunction

  // backoff cycles; reserved codes behave as zero wait
  function automatic logic [BOFF_W-1:0] backoff_cycles(input logic [3:0] code,
                                                       input logic [BOFF_W-1:0] base);
    if (code == 4'h0 || code > BOFF_SHORT_MAX) begin
      return '0;
    end else if (code <= BOFF_LONG_MAX) begin
      return base << (code + BOFF_LONG_ADJ);
    end else begin
      return base << (code - BOFF_SHORT_MIN);
    end
  endfunction
endpackage

/* verilog/dma_stream_fifo.sv */
`timescale 1ns/1ps
module dma_stream_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 32
) (
  input  logic             clk_in,
  input  logic             rst_in,
  input  logic             ce_in,
  input  logic             flush_in,
  input  logic             in_en_in,
  input  logic             in_valid_in,
  input  logic [WIDTH-1:0] in_data_in,
  output logic             in_ready_out,
  output logic             out_valid_out,
  output logic [WIDTH-1:0] out_data_out,
  input  logic             out_ready_in,
  output logic             empty_out
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wptr_q;
  logic [AW-1:0]    rptr_q;
  logic [AW:0]      cnt_q;
  logic [AW:0]      cnt_d;
  logic             in_ready_q;
  logic             out_valid_q;
  logic [WIDTH-1:0] out_data_q;
  wire              push;
  wire              pop;

  // ready is registered from the next fill level, so it never lies
  assign push  = in_valid_in && in_ready_q && !flush_in;
  assign pop   = (cnt_q != '0) && (!out_valid_q || out_ready_in) && !flush_in;
  assign cnt_d = flush_in ? '0 : cnt_q + (AW+1)'(push) - (AW+1)'(pop);

  assign in_ready_out  = in_ready_q;
  assign out_valid_out = out_valid_q;
  assign out_data_out  = out_data_q;
  assign empty_out     = (cnt_q == '0) && !out_valid_q;

  // storage has no reset, contents are don't-care while empty
  always_ff @(posedge clk_in) begin
    if (ce_in && push) begin
      mem_q[wptr_q] <= in_data_in;
    end
  end

  // pointers, level and registered output stage
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wptr_q      <= '0;
      rptr_q      <= '0;
      cnt_q       <= '0;
      in_ready_q  <= 1'b0;
      out_valid_q <= 1'b0;
      out_data_q  <= '0;
    end else if (ce_in) begin
      wptr_q      <= flush_in ? '0 : wptr_q + AW'(push);
      rptr_q      <= flush_in ? '0 : rptr_q + AW'(pop);
      cnt_q       <= cnt_d;
      in_ready_q  <= in_en_in && !flush_in && (cnt_d < (AW+1)'(DEPTH));
      out_valid_q <= !flush_in && (pop || (out_valid_q && !out_ready_in));
      if (pop) begin
        out_data_q <= mem_q[rptr_q];
      end
    end
  end

  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);

  fifo_level_a: assert property (cnt_q <= (AW+1)'(DEPTH))
    else $error("fifo level above depth");
endmodule

/* sim/vme_sink_model.sv */
`timescale 1ns/1ps
module vme_sink_model (
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic hold_in,
  input  wire logic slow_in,
  input  wire logic vme_req_in,
  output logic      vme_gnt_out,
  output logic      sink_ready_out
);
  // grant trails the request by one edge and is held back while stalled
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      vme_gnt_out    <= 1'b0;
      sink_ready_out <= 1'b0;
    end else begin
      vme_gnt_out <= vme_req_in & ~hold_in;
      // mover ready stutters when slow; toggles when stalled, so it means nothing then
      if (hold_in) begin
        sink_ready_out <= ~sink_ready_out;
      end else begin
        sink_ready_out <= slow_in ? 1'($urandom) : 1'b1;
      end
    end
  end
endmodule

/* sim/dma_ctrl_stat_tb.sv */
`timescale 1ns/1ps
`define CHK(a, e) begin \
  comparisons++; \
  if ((a) !== (e)) begin \
    failures++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); \
  end \
end
module dma_ctrl_stat_tb
  import dma_ctrl_pkg::*;
();
  logic        mclk_in, sys_rst_in, ce_in, reg_wr_in, reg_rd_in, pci_master_en_in;
  logic [11:0] reg_addr_in;
  logic [31:0] reg_wdata_in, reg_rdata_out, src_data_in, sink_data_out, cfg, w, e;
  logic [2:0]  pci_addr_lo_in, vme_addr_lo_in;
  logic        pci_err_in, vme_err_in, packet_done_in, xfer_done_in, pci_dma_irq_en_in;
  logic        src_valid_in, src_ready_out, sink_valid_out, sink_ready_in, vme_gnt_in;
  logic        vme_req_out, start_out, chain_mode_out, running_out, irq_out, hold, slow;
  logic        rd_seen, req_p, fell;
  logic [31:0] rq[$], dq[$];
  int          bq[$], gq[$];
  int          failures, comparisons, bcnt, gap, got;

  dma_ctrl_stat #(.BACKOFF_BASE_CYC_P(20'h00004)) uut (
    .mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .ce_in(ce_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
    .pci_master_en_in(pci_master_en_in), .pci_addr_lo_in(pci_addr_lo_in),
    .vme_addr_lo_in(vme_addr_lo_in), .pci_err_in(pci_err_in), .vme_err_in(vme_err_in),
    .packet_done_in(packet_done_in), .xfer_done_in(xfer_done_in),
    .pci_dma_irq_en_in(pci_dma_irq_en_in), .src_valid_in(src_valid_in),
    .src_data_in(src_data_in), .src_ready_out(src_ready_out),
    .sink_valid_out(sink_valid_out), .sink_data_out(sink_data_out),
    .sink_ready_in(sink_ready_in), .vme_gnt_in(vme_gnt_in), .vme_req_out(vme_req_out),
    .start_out(start_out), .chain_mode_out(chain_mode_out), .running_out(running_out),
    .irq_out(irq_out)
  );

  vme_sink_model far_side (
    .clk_in(mclk_in), .rst_in(sys_rst_in), .hold_in(hold), .slow_in(slow),
    .vme_req_in(vme_req_out), .vme_gnt_out(vme_gnt_in), .sink_ready_out(sink_ready_in)
  );

  initial begin
    mclk_in = 1'b0;
    forever #2 mclk_in = ~mclk_in;
  end

  // answers: read data one cycle after the read edge, words leaving toward the mover
  always @(posedge mclk_in) begin
    if (rd_seen) begin
      e = (rq.size() > 0) ? rq.pop_front() : ~reg_rdata_out;
      `CHK(reg_rdata_out, e)
    end
    rd_seen = (reg_rd_in === 1'b1);
    // a frozen engine moves nothing, so only enabled edges count as beats
    if (ce_in === 1'b1 && sink_valid_out === 1'b1 && sink_ready_in && vme_gnt_in &&
        vme_req_out === 1'b1) begin
      w = (dq.size() > 0) ? dq.pop_front() : ~sink_data_out;
      `CHK(sink_data_out, w)
      bcnt++;
    end
    // tenure lengths and off times between them
    if (req_p && vme_req_out !== 1'b1) begin
      bq.push_back(bcnt);
      bcnt = 0;
      gap = 0;
      fell = 1'b1;
    end
    if (!req_p && vme_req_out === 1'b1 && fell) begin
      gq.push_back(gap);
      fell = 1'b0;
    end
    if (vme_req_out !== 1'b1) gap++;
    req_p = (vme_req_out === 1'b1);
  end

  task automatic complete_run();
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic acc(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    reg_wr_in    <= wr;
    reg_rd_in    <= ~wr;
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    @(posedge mclk_in);
    reg_wr_in <= 1'b0;
    reg_rd_in <= 1'b0;
  endtask

  task automatic wr(input logic [31:0] d);
    acc(1'b1, CTRL_STAT_OFS, d);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    rq.push_back(x);
    acc(1'b0, a, 32'h0000_0000);
  endtask

  // one-cycle event pulse: 0 pci error, 1 vme error, 2 packet end, 3 fetch done
  task automatic pulse(input int s);
    @(posedge mclk_in);
    {pci_err_in, vme_err_in, packet_done_in, xfer_done_in} <= 4'h8 >> s;
    @(posedge mclk_in);
    {pci_err_in, vme_err_in, packet_done_in, xfer_done_in} <= 4'h0;
  endtask

  // offer up to n words; the first word not taken within lim edges ends the offer
  task automatic send(input int n, input int lim, output int cnt);
    logic [31:0] d;
    int          k;
    cnt = 0;
    for (int i = 0; i < n; i++) begin
      d = $urandom;
      src_valid_in <= 1'b1;
      src_data_in  <= d;
      k = 0;
      do begin
        @(posedge mclk_in);
        k++;
      end while (src_ready_out !== 1'b1 && k < lim);
      if (src_ready_out !== 1'b1) break;
      dq.push_back(d);
      cnt++;
    end
    src_valid_in <= 1'b0;
  endtask

  task automatic wait_idle();
    int k;
    k = 0;
    do begin
      @(posedge mclk_in);
      k++;
    end while (running_out !== 1'b0 && k < 3000);
    if (k >= 3000) begin
      failures++;
      complete_run();
    end
  endtask

  initial begin
    {sys_rst_in, ce_in, pci_master_en_in, pci_dma_irq_en_in} = 4'hF;
    {reg_wr_in, reg_rd_in, pci_err_in, vme_err_in, packet_done_in, xfer_done_in} = '0;
    {reg_addr_in, reg_wdata_in, src_data_in, src_valid_in} = '0;
    {pci_addr_lo_in, vme_addr_lo_in, hold, slow, rd_seen, req_p, fell} = '0;
    {failures, comparisons, bcnt, gap} = '0;
    void'($urandom(85));
    repeat (20) @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    rd(CTRL_STAT_OFS, CTRL_STAT_RST);
    rd(12'h224, 32'h0000_0000);
    cfg = $urandom & 32'h087F_006F;
    wr(cfg);
    rd(CTRL_STAT_OFS, cfg);
    `CHK(chain_mode_out, cfg[27])
    // every tenure and off-time code written and read back
    for (int i = 0; i < 16; i++) begin
      cfg = (32'(i & 7) << 20) | (32'(i) << 16);
      wr(cfg);
      rd(CTRL_STAT_OFS, cfg);
    end
    $display("test registers done");
    cfg = 32'h0000_0001;
    // bad launches: master disabled, then address low bits differing
    for (int c = 0; c < 2; c++) begin
      pci_master_en_in <= c[0];
      pci_addr_lo_in   <= c[0] ? 3'h5 : 3'h0;
      wr(cfg | 32'h8000_0000);
      rd(CTRL_STAT_OFS, cfg | 32'h0000_0100);
      `CHK(running_out, 1'b0)
      `CHK(irq_out, 1'b1)
      wr(cfg | 32'h0000_6F00);
    end
    pci_addr_lo_in <= 3'h0;
    $display("test fault done");
    cfg = 32'h0019_0000;
    slow <= 1'b1;
    bq.delete();
    gq.delete();
    bcnt = 0;
    wr(cfg | 32'h8000_0000);
    @(posedge mclk_in);
    `CHK(start_out, 1'b1)
    send(70, 500, got);
    pulse(3);
    wait_idle();
    rd(CTRL_STAT_OFS, cfg | 32'h0000_0800);
    `CHK(bq.size() > 0 ? bq[0] : 0, 64)
    `CHK(gq.size() > 0 && gq[0] >= 8 && gq[0] <= 14, 1'b1)
    wr(cfg | 32'h0000_6F00);
    slow <= 1'b0;
    $display("test tenure done");
    cfg = 32'h0000_0008;
    hold <= 1'b1;
    wr(cfg | 32'h8000_0000);
    send(40, 8, got);
    `CHK(got, 33)
    pulse(3);
    rd(CTRL_STAT_OFS, cfg | 32'h0000_8000);
    // grant returns while enable is low: no word may leave while frozen
    ce_in <= 1'b0;
    hold  <= 1'b0;
    repeat (6) @(posedge mclk_in);
    `CHK(dq.size(), 33)
    ce_in <= 1'b1;
    wait_idle();
    rd(CTRL_STAT_OFS, cfg | 32'h0000_0800);
    `CHK(dq.size(), 0)
    `CHK(irq_out, 1'b1)
    pci_dma_irq_en_in <= 1'b0;
    repeat (3) @(posedge mclk_in);
    `CHK(irq_out, 1'b0)
    pci_dma_irq_en_in <= 1'b1;
    wr(cfg | 32'h0000_6F00);
    repeat (3) @(posedge mclk_in);
    `CHK(irq_out, 1'b0)
    $display("test fill done");
    cfg = 32'h0000_0040;
    hold <= 1'b1;
    wr(cfg | 32'h8000_0000);
    send(10, 500, got);
    wr(cfg | 32'h4000_0000);
    rd(CTRL_STAT_OFS, cfg | 32'h0000_8000);
    hold <= 1'b0;
    wait_idle();
    rd(CTRL_STAT_OFS, cfg | 32'h0000_4000);
    `CHK(dq.size(), 0)
    `CHK(irq_out, 1'b1)
    wr(cfg | 32'h0000_6F00);
    $display("test cease done");
    // pause ignored in direct mode, honoured at packet end in linked mode
    for (int m = 0; m < 2; m++) begin
      cfg = m[0] ? 32'h0800_0020 : 32'h0000_0000;
      // host keeps count zero, packets aligned
      wr(cfg | 32'h8000_0000);
      wr(cfg | 32'h2000_0000);
      rd(CTRL_STAT_OFS, cfg | 32'h0000_8000);
      `CHK(chain_mode_out, m[0])
      pulse(m[0] ? 2 : 3);
      wait_idle();
      rd(CTRL_STAT_OFS, cfg | (m[0] ? 32'h0000_2000 : 32'h0000_0800));
      `CHK(irq_out, m[0])
      wr(cfg | 32'h0000_6F00);
    end
    $display("test pause done");
    // errors on each side, with the interrupt enable off and on
    for (int x = 0; x < 4; x++) begin
      cfg = x[1] ? 32'h0000_0006 : 32'h0000_0000;
      wr(cfg | 32'h8000_0000);
      pulse(x[0]);
      wait_idle();
      rd(CTRL_STAT_OFS, cfg | (x[0] ? 32'h0000_0200 : 32'h0000_0400));
      `CHK(irq_out, x[1])
      wr(cfg | 32'h0000_6F00);
      rd(CTRL_STAT_OFS, cfg);
    end
    $display("test errors done");
    // a reset while idle, after every field is written, clears every configured field
    wr(32'h087F_006F);
    sys_rst_in <= 1'b1;
    @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    rd(CTRL_STAT_OFS, CTRL_STAT_RST);
    `CHK(chain_mode_out, 1'b0)
    $display("test reset done");
    complete_run();
  end
endmodule
